// ---- hdl/pt_cmd_decoder.v ----
`timescale 1ns/100ps
// Contract
// - Command 6,0 with entry 01..FF returns that entry's dwell.
// - Command 6,4 with entry 01..FF returns that entry's auxiliary function.
// - Command 4,5 with entry 01..FF returns that entry's M code.
// - Command C,0 with entry and data writes the entry position.
// - Command C,6 writes the entry speed.
// - Command C,7 writes the entry acceleration time constant.
// - Command C,8 writes the entry deceleration time constant.
// - Command C,A writes the entry dwell.
// - Command C,B writes the entry auxiliary function.
// - Command C,B with data bit 15 set writes the entry M code instead of the auxiliary function.
// - Write mode 0 updates RAM and storage; 1 updates RAM only.
// - Command 9,F data number 00 stores the group designation.
// - Frames addressed to our group, once it is set, are accepted like own-station frames but get no reply.
// - Command 1,F data number 00 reads back the group designation.
// - Command 0,2 data number 90 returns position in encoder pulses.
// - Pulse position counter overflows at 8192 revolutions from home.
// - Command 0,2 data number 91 returns position in command units.
// - Position replies are raw hex values; host converts to decimal.
// - Command 0,2 data number 70 returns the software version.
`include "pt_cmd_defs.vh"
module pt_cmd_decoder (
  input  wire        ref_clk_i,      // System clock
  input  wire        rst_i,          // Sync reset, active high
  input  wire        cmd_valid_i,    // Parsed frame strobe
  input  wire [3:0]  station_i,      // Frame station or group address
  input  wire        group_addr_i,   // Frame addresses a group
  input  wire [3:0]  own_station_i,  // This station number
  input  wire [7:0]  cmd_i,          // Command code
  input  wire [7:0]  dno_i,          // Data number
  input  wire [3:0]  wmode_i,        // Write mode digit
  input  wire [31:0] data_i,         // Write data
  input  wire [31:0] pos_pulse_i,    // Motor pulse position
  input  wire [31:0] pos_cmd_i,      // Command unit position
  output reg         rsp_valid_o,    // Reply strobe
  output reg         rsp_err_o,      // Reply is an error
  output reg  [31:0] rsp_data_o,     // Reply value
  output reg         nv_wr_o,        // Storage write strobe
  output reg  [2:0]  nv_field_o,     // Storage field
  output reg  [7:0]  nv_entry_o,     // Storage entry
  output reg  [31:0] nv_data_o       // Storage data
);
  // ****************************************
  // Point table RAM
  // ****************************************
  reg [31:0] pos_mem   [0:255];
  reg [31:0] speed_mem [0:255];
  reg [31:0] acc_mem   [0:255];
  reg [31:0] dec_mem   [0:255];
  reg [31:0] dwell_mem [0:255];
  reg [31:0] aux_mem   [0:255];
  reg [31:0] mcode_mem [0:255];
  reg [3:0]  group_q;
  reg        grp_set_q;
  reg        addressed;
  reg        is_entry;
  reg        is_write;
  reg        known;
  reg [2:0]  wfield;
  reg [31:0] rd_val;
  reg        rsp_valid_d;
  reg        rsp_err_d;
  reg [31:0] rsp_data_d;
  reg        nv_wr_d;
  reg [2:0]  nv_field_d;
  reg [7:0]  nv_entry_d;
  reg [31:0] nv_data_d;
  reg [3:0]  group_d;
  reg        grp_set_d;
  reg [6:0]  wr_sel;
  wire       take;
  wire       commit;
  // Pulse count wraps beyond 8192 revolutions
  localparam [31:0] PULSE_MASK =
    (32'h1 << `ABS_PULSE_W) - 32'h1;

  // ****************************************
  // Helpers
  // ****************************************
  function entry_ok;
    input [7:0] dno;
    begin
      entry_ok = (dno >= `ENTRY_MIN);
    end
  endfunction

  function addr_match;
    input       grp_frame;
    input [3:0] station;
    input [3:0] own;
    input [3:0] group;
    input       group_set;
    begin
      if (grp_frame)
        addr_match = group_set && (station == group);
      else
        addr_match = (station == own);
    end
  endfunction

  function wmode_ok;
    input [3:0] mode;
    begin
      case (mode)
        `WMODE_BOTH: wmode_ok = 1'b1;
        `WMODE_RAM:  wmode_ok = 1'b1;
        default:     wmode_ok = 1'b0;
      endcase
    end
  endfunction

  function to_storage;
    input [3:0] mode;
    begin
      to_storage = (mode == `WMODE_BOTH);
    end
  endfunction

  function [31:0] pulse_wrap;
    input [31:0] pos;
    begin
      pulse_wrap = pos & PULSE_MASK;
    end
  endfunction

  function [6:0] field_onehot;
    input [2:0] sel;
    begin
      case (sel)
        `FLD_POS:   field_onehot = 7'h01;
        `FLD_SPEED: field_onehot = 7'h02;
        `FLD_ACC:   field_onehot = 7'h04;
        `FLD_DEC:   field_onehot = 7'h08;
        `FLD_DWELL: field_onehot = 7'h10;
        `FLD_AUX:   field_onehot = 7'h20;
        default:    field_onehot = 7'h40;
      endcase
    end
  endfunction

  // ****************************************
  // Decode
  // ****************************************
  always @* begin
    addressed = addr_match(group_addr_i, station_i, own_station_i,
                           group_q, grp_set_q);
    is_entry  = entry_ok(dno_i);
    is_write  = 1'b0;
    known     = 1'b1;
    wfield    = `FLD_POS;
    rd_val    = 32'h00000000;
    case (cmd_i)
      `CMD_RD_DWELL: begin
        rd_val = dwell_mem[dno_i];
        known  = is_entry;
      end
      `CMD_RD_AUX: begin
        rd_val = aux_mem[dno_i];
        known  = is_entry;
      end
      `CMD_RD_MCODE: begin
        rd_val = mcode_mem[dno_i];
        known  = is_entry;
      end
      `CMD_WR_POS: begin
        is_write = 1'b1;
        wfield   = `FLD_POS;
        known    = is_entry;
      end
      `CMD_WR_SPEED: begin
        is_write = 1'b1;
        wfield   = `FLD_SPEED;
        known    = is_entry;
      end
      `CMD_WR_ACC: begin
        is_write = 1'b1;
        wfield   = `FLD_ACC;
        known    = is_entry;
      end
      `CMD_WR_DEC: begin
        is_write = 1'b1;
        wfield   = `FLD_DEC;
        known    = is_entry;
      end
      `CMD_WR_DWELL: begin
        is_write = 1'b1;
        wfield   = `FLD_DWELL;
        known    = is_entry;
      end
      `CMD_WR_AUX: begin
        is_write = 1'b1;
        wfield   = data_i[`AUX_MCODE_BIT] ? `FLD_MCODE
                                          : `FLD_AUX;
        known    = is_entry;
      end
      `CMD_WR_GROUP: begin
        known = (dno_i == `DNO_GROUP);
      end
      `CMD_RD_GROUP: begin
        rd_val = {28'h0000000, group_q};
        known  = (dno_i == `DNO_GROUP);
      end
      `CMD_RD_STATUS: begin
        case (dno_i)
          `DNO_ABS_PULSE: rd_val = pulse_wrap(pos_pulse_i);
          `DNO_ABS_CMD:   rd_val = pos_cmd_i;
          `DNO_VERSION:   rd_val = `SW_VERSION;
          default:        known  = 1'b0;
        endcase
      end
      default: known = 1'b0;
    endcase
    if (is_write && !wmode_ok(wmode_i))
      known = 1'b0;
  end

  // ****************************************
  // Frame acceptance
  // ****************************************
  assign take   = cmd_valid_i && addressed;
  assign commit = take && known && is_write;

  always @* begin
    wr_sel = 7'h00;
    if (commit && !rst_i)
      wr_sel = field_onehot(wfield);
  end

  // ****************************************
  // Table writes
  // ****************************************
  always @(posedge ref_clk_i) begin
    if (wr_sel[`FLD_POS])
      pos_mem[dno_i] <= data_i;
    if (wr_sel[`FLD_SPEED])
      speed_mem[dno_i] <= data_i;
    if (wr_sel[`FLD_ACC])
      acc_mem[dno_i] <= data_i;
    if (wr_sel[`FLD_DEC])
      dec_mem[dno_i] <= data_i;
    if (wr_sel[`FLD_DWELL])
      dwell_mem[dno_i] <= data_i;
    if (wr_sel[`FLD_AUX])
      aux_mem[dno_i] <= data_i;
    if (wr_sel[`FLD_MCODE])
      mcode_mem[dno_i] <= data_i;
  end

  // ****************************************
  // Next reply, group and storage values
  // ****************************************
  always @* begin
    rsp_valid_d = take && !group_addr_i;
    rsp_err_d   = !known;
    rsp_data_d  = 32'h00000000;
    nv_wr_d     = 1'b0;
    nv_field_d  = nv_field_o;
    nv_entry_d  = nv_entry_o;
    nv_data_d   = nv_data_o;
    group_d     = group_q;
    grp_set_d   = grp_set_q;
    if (known)
      rsp_data_d = rd_val;
    if (commit) begin
      nv_wr_d    = to_storage(wmode_i);
      nv_field_d = wfield;
      nv_entry_d = dno_i;
      nv_data_d  = data_i;
    end
    if (take && known && cmd_i == `CMD_WR_GROUP) begin
      group_d   = data_i[3:0];
      grp_set_d = 1'b1;
    end
  end

  // ****************************************
  // Reply, group and storage registers
  // ****************************************
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      group_q     <= 4'h0;
      grp_set_q   <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_err_o   <= 1'b0;
      rsp_data_o  <= 32'h00000000;
      nv_wr_o     <= 1'b0;
      nv_field_o  <= 3'h0;
      nv_entry_o  <= 8'h00;
      nv_data_o   <= 32'h00000000;
    end else begin
      group_q     <= group_d;
      grp_set_q   <= grp_set_d;
      rsp_valid_o <= rsp_valid_d;
      rsp_err_o   <= rsp_err_d;
      rsp_data_o  <= rsp_data_d;
      nv_wr_o     <= nv_wr_d;
      nv_field_o  <= nv_field_d;
      nv_entry_o  <= nv_entry_d;
      nv_data_o   <= nv_data_d;
    end
  end
endmodule

// ---- hdl/pt_cmd_defs.vh ----
`ifndef PT_CMD_DEFS_VH
`define PT_CMD_DEFS_VH
// Command codes (two hex characters packed as 8 bits)
`define CMD_RD_DWELL   8'h60
`define CMD_RD_AUX     8'h64
`define CMD_RD_MCODE   8'h45
`define CMD_WR_POS     8'hC0
`define CMD_WR_SPEED   8'hC6
`define CMD_WR_ACC     8'hC7
`define CMD_WR_DEC     8'hC8
`define CMD_WR_DWELL   8'hCA
`define CMD_WR_AUX     8'hCB
`define CMD_WR_GROUP   8'h9F
`define CMD_RD_GROUP   8'h1F
`define CMD_RD_STATUS  8'h02
// Data numbers
`define DNO_GROUP      8'h00
`define DNO_ABS_PULSE  8'h90
`define DNO_ABS_CMD    8'h91
`define DNO_VERSION    8'h70
`define ENTRY_MIN      8'h01
// Write mode digit
`define WMODE_BOTH     4'h0
`define WMODE_RAM      4'h1
// Field selects of the point table
`define FLD_POS        3'h0
`define FLD_SPEED      3'h1
`define FLD_ACC        3'h2
`define FLD_DEC        3'h3
`define FLD_DWELL      3'h4
`define FLD_AUX        3'h5
`define FLD_MCODE      3'h6
// Aux-write data with bit 15 set addresses the M code
`define AUX_MCODE_BIT  15
// Pulse counter wraps at 8192 revolutions
`define ENC_PPR_LOG2   18
`define REV_LIMIT_LOG2 13
`define ABS_PULSE_W    31
// Version (arbitrary value)
`define SW_VERSION     32'h00010000
`endif

// ---- sim/host_model.sv ----
`timescale 1ns/100ps
module host_model (
  input  wire        ref_clk_i, // Clock
  output reg         valid_o,   // Frame strobe
  output reg  [3:0]  station_o, // Station or group
  output reg         group_o,   // Group frame
  output reg  [7:0]  cmd_o,     // Command
  output reg  [7:0]  dno_o,     // Data number
  output reg  [3:0]  wmode_o,   // Write mode
  output reg  [31:0] data_o     // Write data
);
  initial {valid_o, station_o, group_o, cmd_o, dno_o, wmode_o, data_o} = 0;
  task send(input [3:0] s, input g, input [7:0] c, d, input [3:0] w,
            input [31:0] v);
    @(negedge ref_clk_i);
    {station_o, group_o, cmd_o, dno_o, wmode_o, data_o} = {s, g, c, d, w, v};
    valid_o = 1'h1;
    @(negedge ref_clk_i);
    valid_o = 1'h0;
    data_o = ~data_o;
  endtask
endmodule

// ---- sim/pt_cmd_decoder_asserts.sv ----
`timescale 1ns/100ps
`include "pt_cmd_defs.vh"
module pt_cmd_decoder_asserts (
  input wire        ref_clk_i,     // Clock
  input wire        rst_i,         // Reset
  input wire        cmd_valid_i,   // Strobe
  input wire [3:0]  station_i,     // Station
  input wire        group_addr_i,  // Group frame
  input wire [3:0]  own_station_i, // Own station
  input wire [7:0]  cmd_i,         // Command
  input wire [7:0]  dno_i,         // Data number
  input wire [3:0]  wmode_i,       // Write mode
  input wire [31:0] data_i,        // Write data
  input wire [31:0] pos_cmd_i,     // Command position
  input wire        rsp_valid_o,   // Reply strobe
  input wire        rsp_err_o,     // Reply error
  input wire [31:0] rsp_data_o,    // Reply value
  input wire        nv_wr_o,       // Storage strobe
  input wire [2:0]  nv_field_o,    // Storage field
  input wire [7:0]  nv_entry_o,    // Storage entry
  input wire [31:0] nv_data_o      // Storage data
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence own_req;
    cmd_valid_i && !group_addr_i && station_i == own_station_i;
  endsequence
  sequence own_cmd(c, n);
    own_req ##0 cmd_i == c && dno_i == n;
  endsequence
  a_other_silent: assert property (cmd_valid_i && !group_addr_i &&
    station_i != own_station_i |=> !rsp_valid_o && !nv_wr_o)
    else $error("reply to another station");
  a_group_quiet: assert property (cmd_valid_i && group_addr_i |=>
    !rsp_valid_o) else $error("reply to a group frame");
  a_ram_only: assert property (own_req ##0 cmd_i[7:4] == 4'hC &&
    wmode_i == `WMODE_RAM |=> !nv_wr_o) else $error("storage written");
  a_store_pos: assert property (own_req ##0 cmd_i == `CMD_WR_POS &&
    dno_i != 8'h00 && wmode_i == `WMODE_BOTH |=> nv_wr_o &&
    nv_field_o == `FLD_POS && nv_entry_o == $past(dno_i) &&
    nv_data_o == $past(data_i)) else $error("position not stored");
  a_err_clean: assert property (rsp_valid_o && rsp_err_o |->
    rsp_data_o == 32'h0 && !nv_wr_o) else $error("error reply dirty");
  a_bad_entry: assert property (own_cmd(`CMD_WR_SPEED, 8'h00) |=>
    rsp_valid_o && rsp_err_o) else $error("entry zero accepted");
  a_version_rd:
    assert property (own_cmd(`CMD_RD_STATUS, `DNO_VERSION) |=> rsp_valid_o
      && rsp_data_o == `SW_VERSION) else $error("wrong version");
  a_abs_cmd_rd:
    assert property (own_cmd(`CMD_RD_STATUS, `DNO_ABS_CMD) |=>
      rsp_data_o == $past(pos_cmd_i)) else $error("wrong position");
endmodule
bind pt_cmd_decoder pt_cmd_decoder_asserts chk_u (.ref_clk_i, .rst_i,
  .cmd_valid_i, .station_i, .group_addr_i, .own_station_i, .cmd_i, .dno_i,
  .wmode_i, .data_i, .pos_cmd_i, .rsp_valid_o, .rsp_err_o, .rsp_data_o,
  .nv_wr_o, .nv_field_o, .nv_entry_o, .nv_data_o);

// ---- sim/servo_point_table_command_decoder_tb.sv ----
`timescale 1ns/100ps
`include "pt_cmd_defs.vh"
module servo_point_table_command_decoder_tb;
  localparam [55:0] WR = {8'hCB, `CMD_WR_AUX, `CMD_WR_DWELL, `CMD_WR_DEC,
    `CMD_WR_ACC, `CMD_WR_SPEED, `CMD_WR_POS};
  localparam [55:0] RD = {`CMD_RD_MCODE, `CMD_RD_AUX, `CMD_RD_DWELL, 32'h0};
  reg         ref_clk_i = 1'h0;
  reg         rst_i     = 1'h1;
  reg  [31:0] pp = 32'h0, pc = 32'h0, x, y;
  wire        v, g, rv, re, nw;
  wire [3:0]  st, wm;
  wire [7:0]  c, d, ne;
  wire [2:0]  nf;
  wire [31:0] dt, rd, nd;
  integer     seed = 32'hf1c3ccdd, n_fail = 0, n_compared = 0, i;
  always #10 ref_clk_i = ~ref_clk_i;
  host_model host_u (.ref_clk_i, .valid_o(v), .station_o(st), .group_o(g),
    .cmd_o(c), .dno_o(d), .wmode_o(wm), .data_o(dt));
  pt_cmd_decoder dut_u (.ref_clk_i, .rst_i, .cmd_valid_i(v), .station_i(st),
    .group_addr_i(g), .own_station_i(4'h3), .cmd_i(c), .dno_i(d),
    .wmode_i(wm), .data_i(dt), .pos_pulse_i(pp), .pos_cmd_i(pc),
    .rsp_valid_o(rv), .rsp_err_o(re), .rsp_data_o(rd), .nv_wr_o(nw),
    .nv_field_o(nf), .nv_entry_o(ne), .nv_data_o(nd));
  function [2:0] fld(input [7:0] k, input b15);
    fld = k == `CMD_WR_POS ? `FLD_POS : k == `CMD_WR_SPEED ? `FLD_SPEED :
      k == `CMD_WR_ACC ? `FLD_ACC : k == `CMD_WR_DEC ? `FLD_DEC :
      k == `CMD_WR_DWELL ? `FLD_DWELL : b15 ? `FLD_MCODE : `FLD_AUX;
  endfunction
  task check(input [39:0] nm, input [47:0] seen, exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Flags expected as {reply, store, error}
  task ask(input [3:0] s, input gp, input [7:0] k, n, input [3:0] w,
           input [31:0] val, input [2:0] ex, input [31:0] ed);
    host_u.send(s, gp, k, n, w, val);
    check("flags", {rv, nw, re & rv}, ex);
    if (ex[2])
      check("data", rd, ed);
    if (ex[1] && k[7:4] == 4'hC)
      check("store", {nf, ne, nd}, {fld(k, val[15]), n, val});
  endtask
  task test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge ref_clk_i);
    rst_i = 1'h0;
    for (i = 0; i < 7; i = i + 1) begin
      x = $random(seed);
      y = {$random(seed)} % 255 + 1;
      x[15] = i == 6;
      x[16] = i == 1 || (i > 1 && x[16]);
      ask(3, 0, WR[8*i +: 8], y, x[16], x, {2'h2 | !x[16], 1'h0}, 0);
      if (i > 3)
        ask(3, 0, RD[8*i +: 8], y, 0, 0, 3'h4, x);
    end
    ask(3, 0, `CMD_WR_SPEED, 8'h00, 0, x, 3'h5, 0);
    ask(3, 0, `CMD_WR_AUX, y, 4'h2, ~x | 32'h8000, 3'h5, 0);
    ask(3, 0, 8'h77, y, 0, x, 3'h5, 0);
    ask(3, 0, `CMD_RD_STATUS, 8'h55, 0, x, 3'h5, 0);
    ask(5, 0, `CMD_WR_AUX, y, 0, ~x, 3'h0, 0);
    ask(3, 0, `CMD_RD_MCODE, y, 0, 0, 3'h4, x);
    ask(3, 0, `CMD_WR_DWELL, y, 1, x, 3'h4, 0);
    ask(4'h0, 1, `CMD_WR_DWELL, y, 1, 0, 3'h0, 0);
    ask(3, 0, `CMD_RD_DWELL, y, 0, 0, 3'h4, x);
    ask(3, 0, `CMD_WR_GROUP, `DNO_GROUP, 1, 32'hA, 3'h4, 0);
    ask(3, 0, `CMD_RD_GROUP, `DNO_GROUP, 0, 0, 3'h4, 32'hA);
    ask(4'hA, 1, `CMD_WR_DWELL, y, 1, ~x, 3'h0, 0);
    ask(3, 0, `CMD_RD_DWELL, y, 0, 0, 3'h4, ~x);
    ask(4'hB, 1, `CMD_WR_DWELL, y, 0, x, 3'h0, 0);
    ask(3, 0, `CMD_RD_DWELL, y, 0, 0, 3'h4, ~x);
    pp = $random(seed) | 32'h80000000;
    pc = $random(seed);
    ask(3, 0, `CMD_RD_STATUS, `DNO_ABS_PULSE, 0, 0, 3'h4, pp & 32'h7FFFFFFF);
    ask(3, 0, `CMD_RD_STATUS, `DNO_ABS_CMD, 0, 0, 3'h4, pc);
    ask(3, 0, `CMD_RD_STATUS, `DNO_VERSION, 0, 0, 3'h4, `SW_VERSION);
    test_done;
  end
  initial begin
    #100000;
    n_fail = n_fail + 1;
    test_done;
  end
endmodule
